// [common/rdt_pkg.sv]
package rdt_pkg;

    // Register byte offsets on the APB
    localparam logic [7:0] RDT_OFS_BAUD_CTRL  = 8'h00;
    localparam logic [7:0] RDT_OFS_TX_CTRL    = 8'h04;
    localparam logic [7:0] RDT_OFS_RX_CTRL    = 8'h08;
    localparam logic [7:0] RDT_OFS_DIV_LOW    = 8'h0c;
    localparam logic [7:0] RDT_OFS_DIV_HIGH   = 8'h10;

    // Field positions
    localparam int RDT_BIT_RX_IDLE     = 6;
    localparam int RDT_BIT_WIDE        = 3;
    localparam int RDT_BIT_SYNC        = 4;
    localparam int RDT_BIT_HIGH_SPEED  = 2;
    localparam int RDT_BIT_PORT_ENABLE = 7;

    // Writable bits per register
    localparam logic [7:0] RDT_MASK_BAUD_CTRL = 8'h1b;
    localparam logic [7:0] RDT_MASK_TX_CTRL   = 8'hfd;
    localparam logic [7:0] RDT_MASK_RX_CTRL   = 8'hf8;

    // Reset values
    localparam logic [7:0] RDT_RST_BAUD_CTRL  = 8'h00;
    localparam logic [7:0] RDT_RST_TX_CTRL    = 8'h02;
    localparam logic [7:0] RDT_RST_RX_CTRL    = 8'h00;
    localparam logic [7:0] RDT_RST_DIV        = 8'h00;

    // Prescale terminal counts: multiplier minus one
    localparam logic [5:0] RDT_PRE_X64 = 6'h3f;
    localparam logic [5:0] RDT_PRE_X16 = 6'h0f;
    localparam logic [5:0] RDT_PRE_X4  = 6'h03;

    typedef struct packed {
        logic enable;
        logic sync;
        logic high_speed;
        logic wide;
    } rdt_cfg_t;

    typedef enum logic [1:0] {
        RDT_BUS_IDLE = 2'b00,
        RDT_BUS_WAIT = 2'b01,
        RDT_BUS_DONE = 2'b11
    } rdt_bus_state_t;

endpackage : rdt_pkg

// [tb/rdt_props.sv]
`timescale 1ns/1ps
module rdt_props (
    input wire logic        MCLK_I,
    input wire logic        SYS_RST_I,
    input wire logic        PSEL_I,
    input wire logic        PENABLE_I,
    input wire logic        PWRITE_I,
    input wire logic [7:0]  PADDR_I,
    input wire logic [31:0] PWDATA_I,
    input wire logic [31:0] PRDATA_O,
    input wire logic        PREADY_O,
    input wire logic        PSLVERR_O,
    input wire logic        RATE_TICK_O,
    input wire logic        SYNC_MODE_O
);
    import rdt_pkg::*;
    default clocking @(posedge MCLK_I);
    endclocking
    default disable iff (SYS_RST_I);
    sequence s_access;
        PSEL_I && $rose(PENABLE_I);
    endsequence
    sequence s_wait;
        !PREADY_O ##1 !PREADY_O ##1 PREADY_O;
    endsequence
    logic wr_done;
    assign wr_done = PREADY_O && PWRITE_I;
    a_ready_delay: assert property (s_access |-> s_wait)
        else $error("ready not two cycles after access");
    a_ready_pulse: assert property (PREADY_O |=> !PREADY_O)
        else $error("ready longer than one cycle");
    a_err_ready: assert property (PSLVERR_O |-> PREADY_O)
        else $error("error without ready");
    a_err_addr: assert property (PREADY_O && PADDR_I > RDT_OFS_DIV_HIGH |-> PSLVERR_O)
        else $error("unmapped access not flagged");
    a_rdata_quiet: assert property (!PREADY_O |-> PRDATA_O == 32'h0)
        else $error("read data outside ready");
    a_tick_spacing: assert property (RATE_TICK_O |=> !RATE_TICK_O [*3])
        else $error("ticks closer than four clocks");
    a_div_restart: assert property (wr_done
        && (PADDR_I == RDT_OFS_DIV_LOW || PADDR_I == RDT_OFS_DIV_HIGH)
        |=> !RATE_TICK_O [*3])
        else $error("tick too soon after divisor write");
    a_sync_copy: assert property (wr_done && PADDR_I == RDT_OFS_TX_CTRL
        |-> ##2 SYNC_MODE_O == $past(PWDATA_I[RDT_BIT_SYNC], 2))
        else $error("sync output not following select");
endmodule : rdt_props
bind rdt_top rdt_props u_props (.MCLK_I(MCLK_I), .SYS_RST_I(SYS_RST_I), .PSEL_I(PSEL_I),
    .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I),
    .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O),
    .RATE_TICK_O(RATE_TICK_O), .SYNC_MODE_O(SYNC_MODE_O));

// [tb/rdt_shift_model.sv]
`timescale 1ns/1ps
module rdt_shift_model (
    // Clock and tick
    input  wire logic clk_i,
    input  wire logic tick_i,
    // Receiver activity
    input  wire logic busy_i,
    output logic      rx_idle_o,
    output int        period_o
);
    int cnt_q;
    // Spacing between ticks, as the shift logic sees it
    always_ff @(posedge clk_i) begin
        cnt_q <= tick_i ? 1 : cnt_q + 1;
        if (tick_i) period_o <= cnt_q;
    end
    assign rx_idle_o = !busy_i;
endmodule : rdt_shift_model

// [tb/tb.sv]
`timescale 1ns/1ps
module tb;
    import rdt_pkg::*;
    logic        clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, busy = 0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, rd, prdata;
    logic        pready, pslverr, tick, sync_mode, rx_idle, err;
    int          period, first, miscompares = 0, checks = 0;
    // Tick spacing per {sync, high speed, wide} with divisor 0x0102
    int          exp_m [8] = '{192, 4144, 48, 1036, 12, 1036, 12, 1036};
    rdt_top dut_u (.MCLK_I(clk), .SYS_RST_I(rst), .PSEL_I(psel), .PENABLE_I(penable),
        .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
        .PREADY_O(pready), .PSLVERR_O(pslverr), .RX_IDLE_I(rx_idle),
        .RATE_TICK_O(tick), .SYNC_MODE_O(sync_mode));
    rdt_shift_model shift_u (.clk_i(clk), .tick_i(tick), .busy_i(busy),
        .rx_idle_o(rx_idle), .period_o(period));
    initial begin
        forever #20 clk = ~clk;
    end
    task automatic results;
        if (miscompares == 0 && checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : results
    task automatic check(input logic [31:0] s, input logic [31:0] e);
        checks++;
        if (s !== e) begin
            miscompares++;
            $display("BAD %0t seen %h expected %h", $time, s, e);
        end
    endtask : check
    // Request held until ready is sampled high at a rising edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            miscompares++;
            results();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // Counts edges from the divisor write to the first tick seen
    task automatic ticks(input int k, output int f);
        int n = 0;
        f = 0;
        while (k > 0 && n < 20000) begin
            @(posedge clk);
            n++;
            if (tick === 1'b1) begin
                if (f == 0) f = n;
                k--;
            end
        end
        // Let the model settle its period before anyone reads it
        @(negedge clk);
        if (k > 0) begin
            miscompares++;
            results();
        end
    endtask : ticks
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        apb(0, RDT_OFS_BAUD_CTRL, 0); check(rd, 32'h40);
        apb(0, RDT_OFS_TX_CTRL, 0); check(rd, 32'h02);
        apb(0, RDT_OFS_DIV_HIGH, 0); check(rd, 32'h0);
        apb(0, 8'h14, 0); check({rd[31:1], err}, 32'h1);
        apb(1, RDT_OFS_BAUD_CTRL, 32'hff);
        apb(0, RDT_OFS_BAUD_CTRL, 0); check(rd, 32'h5b);
        apb(1, RDT_OFS_TX_CTRL, 32'h0);
        apb(0, RDT_OFS_TX_CTRL, 0); check(rd, 32'h02);
        apb(1, RDT_OFS_DIV_HIGH, 32'h01);
        apb(1, RDT_OFS_RX_CTRL, 32'h80);
        for (int i = 0; i < 8; i++) begin
            apb(1, RDT_OFS_BAUD_CTRL, 32'({i[0], 3'b000}));
            apb(1, RDT_OFS_TX_CTRL, 32'({i[2], 1'b0, i[1], 2'b00}));
            // Low byte write also restarts the count for the new mode
            apb(1, RDT_OFS_DIV_LOW, 32'h02);
            ticks(3, first);
            check(first, exp_m[i] + 1);
            check(period, exp_m[i]);
            check(32'(sync_mode), 32'(i[2]));
        end
        busy <= 1'b1;
        apb(0, RDT_OFS_BAUD_CTRL, 0); check(rd, 32'h08);
        results();
    end
endmodule : tb

// [verilog/rdt_top.sv]
// The register offsets and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
// What this block does
// - Divider timer runs 8 or 16 bits wide, serving async and sync modes.
// - Divider starts 8 bits wide after reset; wide select makes it 16 bits.
// - Divisor byte pair sets the period of the free-running rate divider.
// - Async multiplier chosen jointly by high-speed and wide selects.
// - Sync mode ignores high-speed select; width and divisor alone matter.
// - Writing either divisor byte clears the divider timer immediately.
// - Async, 8-bit, low speed: rate is clock over 64 times (n+1).
// - Async, 16-bit, low speed: rate is clock over 16 times (n+1).
// - Sync, either width: rate is clock over 4 times (n+1).
// - Divisor n is the combined high and low divisor byte value in 16-bit mode, the low byte alone in 8-bit mode.
// - Sync mode select set means synchronous, clear means asynchronous.
// - Async high-speed select set means high speed; unused in sync mode.
// - Receiver idle flag reads one when idle, zero while receiving.
module rdt_top (
    // Clock and reset
    input  wire logic        MCLK_I,
    input  wire logic        SYS_RST_I,
    // APB slave
    input  wire logic        PSEL_I,
    input  wire logic        PENABLE_I,
    input  wire logic        PWRITE_I,
    input  wire logic [7:0]  PADDR_I,
    input  wire logic [31:0] PWDATA_I,
    output logic      [31:0] PRDATA_O,
    output logic             PREADY_O,
    output logic             PSLVERR_O,
    // Receiver status in
    input  wire logic        RX_IDLE_I,
    // Shift logic side
    output logic             RATE_TICK_O,
    output logic             SYNC_MODE_O
);
    import rdt_pkg::*;

    rdt_bus_state_t bus_q;
    logic [7:0]     baud_ctrl_q;
    logic [7:0]     tx_ctrl_q;
    logic [7:0]     rx_ctrl_q;
    logic [7:0]     div_low_q;
    logic [7:0]     div_high_q;
    logic [5:0]     pre_q;
    logic [15:0]    cnt_q;
    logic [5:0]     pre_end;
    logic [15:0]    cnt_end;
    logic           wr_go;
    logic           div_write;
    logic           mapped;
    logic [7:0]     rd_byte;
    rdt_cfg_t       cfg;

    // APB: access phase takes two wait states, pready registered
    always_ff @(posedge MCLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            bus_q <= RDT_BUS_IDLE;
        end else begin
            case (bus_q)
                RDT_BUS_IDLE: begin
                    if (PSEL_I && PENABLE_I) begin
                        bus_q <= RDT_BUS_WAIT;
                    end
                end
                RDT_BUS_WAIT: begin
                    bus_q <= RDT_BUS_DONE;
                end
                RDT_BUS_DONE: begin
                    bus_q <= RDT_BUS_IDLE;
                end
                default: begin
                    bus_q <= RDT_BUS_IDLE;
                end
            endcase
        end
    end

    always_comb begin
        mapped  = 1'b1;
        rd_byte = 8'h00;
        if (PADDR_I == RDT_OFS_BAUD_CTRL) begin
            rd_byte = baud_ctrl_q;
            rd_byte[RDT_BIT_RX_IDLE] = RX_IDLE_I;
        end else if (PADDR_I == RDT_OFS_TX_CTRL) begin
            rd_byte = tx_ctrl_q;
        end else if (PADDR_I == RDT_OFS_RX_CTRL) begin
            rd_byte = rx_ctrl_q;
        end else if (PADDR_I == RDT_OFS_DIV_LOW) begin
            rd_byte = div_low_q;
        end else if (PADDR_I == RDT_OFS_DIV_HIGH) begin
            rd_byte = div_high_q;
        end else begin
            mapped = 1'b0;
        end
    end

    // Answer flops: ready and data rise together at the edge that ends the wait state
    always_ff @(posedge MCLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            PREADY_O  <= 1'b0;
            PSLVERR_O <= 1'b0;
            PRDATA_O  <= 32'h0000_0000;
        end else if (bus_q == RDT_BUS_WAIT) begin
            PREADY_O  <= 1'b1;
            PSLVERR_O <= ~mapped;
            PRDATA_O  <= PWRITE_I ? 32'h0000_0000 : {24'h00_0000, rd_byte};
        end else begin
            PREADY_O  <= 1'b0;
            PSLVERR_O <= 1'b0;
            PRDATA_O  <= 32'h0000_0000;
        end
    end

    // Write takes effect at the edge where pready is sampled high
    assign wr_go     = PSEL_I && PENABLE_I && PREADY_O && PWRITE_I;
    assign div_write = wr_go && (PADDR_I == RDT_OFS_DIV_LOW || PADDR_I == RDT_OFS_DIV_HIGH);

    always_ff @(posedge MCLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            baud_ctrl_q <= RDT_RST_BAUD_CTRL;
            tx_ctrl_q   <= RDT_RST_TX_CTRL;
            rx_ctrl_q   <= RDT_RST_RX_CTRL;
            div_low_q   <= RDT_RST_DIV;
            div_high_q  <= RDT_RST_DIV;
        end else if (wr_go) begin
            if (PADDR_I == RDT_OFS_BAUD_CTRL) begin
                baud_ctrl_q <= PWDATA_I[7:0] & RDT_MASK_BAUD_CTRL;
            end else if (PADDR_I == RDT_OFS_TX_CTRL) begin
                tx_ctrl_q <= (PWDATA_I[7:0] & RDT_MASK_TX_CTRL)
                           | (tx_ctrl_q & ~RDT_MASK_TX_CTRL);
            end else if (PADDR_I == RDT_OFS_RX_CTRL) begin
                rx_ctrl_q <= PWDATA_I[7:0] & RDT_MASK_RX_CTRL;
            end else if (PADDR_I == RDT_OFS_DIV_LOW) begin
                div_low_q <= PWDATA_I[7:0];
            end else if (PADDR_I == RDT_OFS_DIV_HIGH) begin
                div_high_q <= PWDATA_I[7:0];
            end
        end
    end

    // One process drives the whole struct; split drivers trip strict tools
    always_comb begin
        cfg.enable     = rx_ctrl_q[RDT_BIT_PORT_ENABLE];
        cfg.sync       = tx_ctrl_q[RDT_BIT_SYNC];
        cfg.high_speed = tx_ctrl_q[RDT_BIT_HIGH_SPEED];
        cfg.wide       = baud_ctrl_q[RDT_BIT_WIDE];
    end

    // Multiplier select
    always_comb begin
        if (cfg.sync) begin
            pre_end = RDT_PRE_X4;
        end else if (!cfg.wide && !cfg.high_speed) begin
            pre_end = RDT_PRE_X64;
        end else if (cfg.wide && !cfg.high_speed) begin
            pre_end = RDT_PRE_X16;
        end else if (!cfg.wide) begin
            pre_end = RDT_PRE_X16;
        end else begin
            pre_end = RDT_PRE_X4;
        end
    end

    // Divisor: high byte dropped in 8-bit mode
    assign cnt_end = cfg.wide ? {div_high_q, div_low_q} : {8'h00, div_low_q};

    // Free-running timer; period is multiplier times (n+1) clocks
    always_ff @(posedge MCLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            pre_q       <= 6'h00;
            cnt_q       <= 16'h0000;
            RATE_TICK_O <= 1'b0;
        end else if (!cfg.enable || div_write) begin
            pre_q       <= 6'h00;
            cnt_q       <= 16'h0000;
            RATE_TICK_O <= 1'b0;
        end else if (pre_q >= pre_end) begin
            // Compare with >= so a mode change never strands the count
            pre_q <= 6'h00;
            if (cnt_q >= cnt_end) begin
                cnt_q       <= 16'h0000;
                RATE_TICK_O <= 1'b1;
            end else begin
                cnt_q       <= cnt_q + 16'h0001;
                RATE_TICK_O <= 1'b0;
            end
        end else begin
            pre_q       <= pre_q + 6'h01;
            RATE_TICK_O <= 1'b0;
        end
    end

    always_ff @(posedge MCLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            SYNC_MODE_O <= 1'b0;
        end else begin
            SYNC_MODE_O <= cfg.sync;
        end
    end

endmodule : rdt_top
